// *** rtl/guest_fault_mpu_regs.sv ***
// guest-mode fault capture, protection mode and virtual core number
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/10ps
// Behaviour
// - guest misaligned or protection fault stores 32-bit faulting address
// - fault records opcode size in bits 31..28 of fault info
// - fault records operand register number in bits 20..16
// - fault records instruction data type in bits 11..9, even if split
// - fault records sign or zero extension in bit 8
// - fault records faulting operation kind in bits 5..1
// - fault records read or write in bit 0
// - reserved bits read zero; software writes zero there
// - host entry enable 0 with guest entry enable 1 means guest entries alone decide in guest mode
// - guest mode cannot change the host entry enable bit
// - guest entries apply to guest supervisor code only if supervisor bit set
// - guest entry enable 0 means only host entries decide
// - protection mode writable by own name even under privilege lock
// - guest write through alias name is blocked while lock set
// - guest context store and load skip the guest core number
// - writable 5-bit virtual core number, read by guest via core number
// - guest writes to ordinary core number leave virtual number unchanged
// - protection mode enables reset to zero
// - privilege lock blocks only guest supervisor writes through the alias protection-mode name
module guest_fault_mpu_regs #(
  parameter logic [4:0] FIXED_CORE_NUM = 5'h00 // arbitrary product value
) (
  input wire logic i_clk, // core clock
  input wire logic i_rst, // synchronous reset, active high
  input wire logic i_psel, // apb select
  input wire logic i_penable, // apb enable
  input wire logic i_pwrite, // apb direction
  input wire logic [7:0] i_paddr, // apb byte address
  input wire logic [31:0] i_pwdata, // apb write data
  input wire logic [3:0] i_pstrb, // apb byte strobes
  input wire logic i_guest_mode, // core runs in guest mode
  input wire logic i_user_mode_flag, // current user-mode flag
  input wire logic i_fault_commit, // exception entry committed
  input wire logic i_misaligned_fault, // fault is misalignment
  input wire logic i_data_prot_fault, // fault is data protection
  input wire logic [31:0] i_fault_address, // faulting address
  input wire logic [3:0] i_opcode_size, // instruction code size
  input wire logic [4:0] i_operand_index, // operand register number
  input wire logic [2:0] i_access_width_type, // instruction data type
  input wire logic i_sign_ext, // load sign extends
  input wire logic [4:0] i_faulting_op_kind, // faulting instruction id
  input wire logic i_fault_write, // fault access is a write
  output logic o_pready, // apb ready
  output logic [31:0] o_prdata, // apb read data
  output logic o_pslverr, // apb error on unmapped address
  output logic o_host_entries_active, // host entries used now
  output logic o_guest_entries_active, // guest entries used now
  output logic [4:0] o_core_number, // core number seen by the core
  output logic [4:0] o_ext_core_number // core number for outside logic
);
  // ==========================================================
  // state
  logic [31:0] fault_addr_q;
  logic [31:0] fault_info_q;
  logic [2:0] prot_mode_q;
  logic [4:0] core_num_q;
  logic lock_q;
  logic access;
  logic wr;
  logic mapped;
  logic guest_fault;
  // ==========================================================
  // address decode and next-state values
  logic setup;
  logic rd_setup;
  logic hit_addr;
  logic hit_info;
  logic hit_pm;
  logic hit_lock;
  logic hit_core;
  logic hit_alias_pm;
  logic alias_ok;
  logic pm_wr;
  logic pready_d;
  logic pslverr_d;
  logic [31:0] prdata_d;
  logic [31:0] fault_addr_d;
  logic [31:0] fault_info_d;
  logic [2:0] prot_mode_d;
  logic [4:0] core_num_d;
  logic lock_d;
  logic host_active_d;
  logic guest_active_d;
  logic [4:0] core_number_d;

  // merge byte lanes of a write into an old word
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                       input logic [31:0] new_v,
                                       input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  assign access = i_psel && i_penable && o_pready;
  assign wr = access && i_pwrite;
  assign guest_fault = i_fault_commit && i_guest_mode &&
                       (i_misaligned_fault || i_data_prot_fault);

  // ==========================================================
  // register decode
  assign setup = i_psel && !i_penable;
  assign rd_setup = setup && !i_pwrite;
  assign hit_addr = i_paddr == guest_fault_mpu_pkg::OFF_FAULT_ADDR;
  assign hit_info = i_paddr == guest_fault_mpu_pkg::OFF_FAULT_INFO;
  assign hit_pm = i_paddr == guest_fault_mpu_pkg::OFF_PROT_MODE;
  assign hit_lock = i_paddr == guest_fault_mpu_pkg::OFF_LOCK;
  assign hit_core = i_paddr == guest_fault_mpu_pkg::OFF_CORE_NUM;
  assign hit_alias_pm = i_paddr == guest_fault_mpu_pkg::OFF_ALIAS_PROT;
  // alias name counts only for guest supervisor code with the lock clear
  assign alias_ok = hit_alias_pm && i_guest_mode && !i_user_mode_flag &&
                    !lock_q;
  // own name is never held back by the lock
  assign pm_wr = wr && i_pstrb[0] && (hit_pm || alias_ok);

  always_comb begin
    case (i_paddr)
      guest_fault_mpu_pkg::OFF_FAULT_ADDR,
      guest_fault_mpu_pkg::OFF_FAULT_INFO,
      guest_fault_mpu_pkg::OFF_PROT_MODE,
      guest_fault_mpu_pkg::OFF_CORE_NUM,
      guest_fault_mpu_pkg::OFF_LOCK,
      guest_fault_mpu_pkg::OFF_ALIAS_PROT,
      guest_fault_mpu_pkg::OFF_ALIAS_CORE,
      guest_fault_mpu_pkg::OFF_STATUS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // ==========================================================
  // apb handshake: one wait-free access phase
  always_comb begin
    pready_d = setup;
    pslverr_d = setup && !mapped;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_pready <= 1'b0;
    end else begin
      o_pready <= pready_d;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_pslverr <= 1'b0;
    end else begin
      o_pslverr <= pslverr_d;
    end
  end

  // ==========================================================
  // fault address capture; hardware capture wins over software write
  always_comb begin
    fault_addr_d = fault_addr_q;
    if (guest_fault) begin
      fault_addr_d = i_fault_address;
    end else if (wr && hit_addr) begin
      fault_addr_d = merge(fault_addr_q, i_pwdata, i_pstrb);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      fault_addr_q <= 32'h0000_0000;
    end else begin
      fault_addr_q <= fault_addr_d;
    end
  end

  // ==========================================================
  // fault information capture
  always_comb begin
    fault_info_d = fault_info_q;
    if (guest_fault) begin
      // reserved fields come out zero
      fault_info_d = 32'h0000_0000;
      fault_info_d[guest_fault_mpu_pkg::INFO_SIZE_LSB +:
                   guest_fault_mpu_pkg::INFO_SIZE_W] = i_opcode_size;
      fault_info_d[guest_fault_mpu_pkg::INFO_OPND_LSB +:
                   guest_fault_mpu_pkg::INFO_OPND_W] =
        i_operand_index;
      // data type as named by the instruction, not per split transfer
      fault_info_d[guest_fault_mpu_pkg::INFO_TYPE_LSB +:
                   guest_fault_mpu_pkg::INFO_TYPE_W] =
        i_access_width_type;
      fault_info_d[guest_fault_mpu_pkg::INFO_SIGN_BIT] =
        i_sign_ext;
      fault_info_d[guest_fault_mpu_pkg::INFO_KIND_LSB +:
                   guest_fault_mpu_pkg::INFO_KIND_W] =
        i_faulting_op_kind;
      fault_info_d[guest_fault_mpu_pkg::INFO_RW_BIT] =
        i_fault_write;
    end else if (wr && hit_info) begin
      fault_info_d = merge(fault_info_q, i_pwdata, i_pstrb) &
                     guest_fault_mpu_pkg::INFO_WMASK;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      fault_info_q <= 32'h0000_0000;
    end else begin
      fault_info_q <= fault_info_d;
    end
  end

  // ==========================================================
  // privilege lock
  always_comb begin
    lock_d = lock_q;
    if (wr && hit_lock && i_pstrb[0]) begin
      lock_d = i_pwdata[0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      lock_q <= guest_fault_mpu_pkg::LOCK_RESET;
    end else begin
      lock_q <= lock_d;
    end
  end

  // ==========================================================
  // protection mode: own name ignores lock, alias name honours it
  always_comb begin
    prot_mode_d = prot_mode_q;
    if (pm_wr) begin
      prot_mode_d[guest_fault_mpu_pkg::PM_SUPV_BIT] =
        i_pwdata[guest_fault_mpu_pkg::PM_SUPV_BIT];
      prot_mode_d[guest_fault_mpu_pkg::PM_GUEST_EN_BIT] =
        i_pwdata[guest_fault_mpu_pkg::PM_GUEST_EN_BIT];
      // guest software never moves the host entry enable
      if (!i_guest_mode) begin
        prot_mode_d[guest_fault_mpu_pkg::PM_HOST_EN_BIT] =
          i_pwdata[guest_fault_mpu_pkg::PM_HOST_EN_BIT];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      prot_mode_q <= guest_fault_mpu_pkg::PM_RESET;
    end else begin
      prot_mode_q <= prot_mode_d;
    end
  end

  // ==========================================================
  // virtual core number; context store/load have no path here
  always_comb begin
    core_num_d = core_num_q;
    if (wr && i_pstrb[0] && !i_guest_mode && hit_core) begin
      core_num_d = i_pwdata[4:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      core_num_q <= guest_fault_mpu_pkg::CORE_RESET;
    end else begin
      core_num_q <= core_num_d;
    end
  end

  // ==========================================================
  // read data, latched in the setup cycle
  always_comb begin
    prdata_d = o_prdata;
    if (rd_setup) begin
      case (i_paddr)
        guest_fault_mpu_pkg::OFF_FAULT_ADDR: begin
          prdata_d = fault_addr_q;
        end
        guest_fault_mpu_pkg::OFF_FAULT_INFO: begin
          prdata_d = fault_info_q;
        end
        guest_fault_mpu_pkg::OFF_PROT_MODE,
        guest_fault_mpu_pkg::OFF_ALIAS_PROT: begin
          prdata_d = {29'h0000_0000, prot_mode_q};
        end
        guest_fault_mpu_pkg::OFF_CORE_NUM: begin
          prdata_d = {27'h0, core_num_q};
        end
        guest_fault_mpu_pkg::OFF_ALIAS_CORE: begin
          prdata_d = {27'h0, i_guest_mode ? core_num_q
                                          : FIXED_CORE_NUM};
        end
        guest_fault_mpu_pkg::OFF_LOCK: begin
          prdata_d = {31'h0, lock_q};
        end
        guest_fault_mpu_pkg::OFF_STATUS: begin
          prdata_d = {30'h0, o_host_entries_active,
                      o_guest_entries_active};
        end
        default: begin
          prdata_d = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_prdata <= 32'h0000_0000;
    end else begin
      o_prdata <= prdata_d;
    end
  end

  // ==========================================================
  // protection decision and core number outputs
  always_comb begin
    // host mode: host entries only; guest mode follows enables
    host_active_d = !i_guest_mode ||
      prot_mode_q[guest_fault_mpu_pkg::PM_HOST_EN_BIT] ||
      !prot_mode_q[guest_fault_mpu_pkg::PM_GUEST_EN_BIT];
    guest_active_d = i_guest_mode &&
      prot_mode_q[guest_fault_mpu_pkg::PM_GUEST_EN_BIT] &&
      (i_user_mode_flag ||
       prot_mode_q[guest_fault_mpu_pkg::PM_SUPV_BIT]);
    core_number_d = i_guest_mode ? core_num_q : FIXED_CORE_NUM;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_host_entries_active <= 1'b1;
    end else begin
      o_host_entries_active <= host_active_d;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_guest_entries_active <= 1'b0;
    end else begin
      o_guest_entries_active <= guest_active_d;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_core_number <= FIXED_CORE_NUM;
    end else begin
      o_core_number <= core_number_d;
    end
  end

  // outside logic never sees the virtual value
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_ext_core_number <= FIXED_CORE_NUM;
    end else begin
      o_ext_core_number <= FIXED_CORE_NUM;
    end
  end
endmodule

// *** rtl/guest_fault_mpu_pkg.sv ***
// constants for the guest-mode fault and protection register bank
package guest_fault_mpu_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFF_FAULT_ADDR = 8'h00;
  localparam logic [7:0] OFF_FAULT_INFO = 8'h04;
  localparam logic [7:0] OFF_PROT_MODE = 8'h08;
  localparam logic [7:0] OFF_CORE_NUM = 8'h0c;
  localparam logic [7:0] OFF_LOCK = 8'h10;
  localparam logic [7:0] OFF_ALIAS_PROT = 8'h14;
  localparam logic [7:0] OFF_ALIAS_CORE = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1c;
  // ==========================================================
  // fault-information field positions
  localparam int INFO_SIZE_LSB = 28;
  localparam int INFO_SIZE_W = 4;
  localparam int INFO_OPND_LSB = 16;
  localparam int INFO_OPND_W = 5;
  localparam int INFO_TYPE_LSB = 9;
  localparam int INFO_TYPE_W = 3;
  localparam int INFO_SIGN_BIT = 8;
  localparam int INFO_KIND_LSB = 1;
  localparam int INFO_KIND_W = 5;
  localparam int INFO_RW_BIT = 0;
  localparam logic [31:0] INFO_WMASK = 32'hf01f_0f3f;
  // ==========================================================
  // protection-mode bits and reset values
  localparam int PM_HOST_EN_BIT = 2;
  localparam int PM_SUPV_BIT = 1;
  localparam int PM_GUEST_EN_BIT = 0;
  localparam logic [2:0] PM_RESET = 3'h0;
  localparam int CORE_W = 5;
  localparam logic [4:0] CORE_RESET = 5'h00;
  localparam logic LOCK_RESET = 1'b0;
endpackage

// *** tb/guest_fault_mpu_regs_asserts.sv ***
// port assertions for the guest fault and protection register bank
`timescale 1ns/10ps
module guest_fault_mpu_regs_asserts #(
  parameter logic [4:0] FIXED_CORE_NUM = 5'h00
) (
  input wire logic i_clk, // core clock
  input wire logic i_rst, // sync reset
  input wire logic i_psel, // apb select
  input wire logic i_penable, // apb enable
  input wire logic i_pwrite, // apb direction
  input wire logic [7:0] i_paddr, // apb address
  input wire logic [31:0] i_pwdata, // apb write data
  input wire logic [3:0] i_pstrb, // apb strobes
  input wire logic i_guest_mode, // guest mode
  input wire logic i_fault_commit, // exception entry
  input wire logic i_misaligned_fault, // misalignment
  input wire logic i_data_prot_fault, // protection fault
  input wire logic [31:0] i_fault_address, // faulting address
  input wire logic o_pready, // apb ready
  input wire logic [31:0] o_prdata, // apb read data
  input wire logic o_host_entries_active, // host entries used
  input wire logic o_guest_entries_active, // guest entries used
  input wire logic [4:0] o_core_number, // core number inside
  input wire logic [4:0] o_ext_core_number // core number outside
);
  logic cap;
  logic rd_end;
  logic [31:0] addr_q;
  assign cap = i_fault_commit & i_guest_mode &
    (i_misaligned_fault | i_data_prot_fault);
  assign rd_end = i_psel & i_penable & o_pready & !i_pwrite;
  // ==========================================================
  // mirror of the fault address register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      addr_q <= 32'h0000_0000;
    end else if (cap) begin
      addr_q <= i_fault_address;
    end else if (i_psel & i_penable & o_pready & i_pwrite &
        i_paddr == 8'h00) begin
      for (int b = 0; b < 4; b++) begin
        if (i_pstrb[b]) begin
          addr_q[8*b+:8] <= i_pwdata[8*b+:8];
        end
      end
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  property p_ext_fixed;
    o_ext_core_number == FIXED_CORE_NUM;
  endproperty
  a_ext_fixed: assert property (p_ext_fixed)
    else $error("outside core number changed");
  property p_host_core;
    !$past(i_guest_mode) |-> o_core_number == FIXED_CORE_NUM;
  endproperty
  a_host_core: assert property (p_host_core)
    else $error("host core number not fixed");
  property p_info_rsvd;
    rd_end && i_paddr == 8'h04 |->
      (o_prdata & ~guest_fault_mpu_pkg::INFO_WMASK) == 32'h0000_0000;
  endproperty
  a_info_rsvd: assert property (p_info_rsvd)
    else $error("fault info reserved bits set");
  property p_pm_rsvd;
    rd_end && i_paddr == 8'h08 |-> o_prdata[31:3] == 29'h0;
  endproperty
  a_pm_rsvd: assert property (p_pm_rsvd)
    else $error("protection mode reserved bits set");
  property p_core_rsvd;
    rd_end && i_paddr == 8'h0c |-> o_prdata[31:5] == 27'h0;
  endproperty
  a_core_rsvd: assert property (p_core_rsvd)
    else $error("core number reserved bits set");
  property p_addr_mirror;
    rd_end && i_paddr == 8'h00 && !$past(cap) |-> o_prdata == addr_q;
  endproperty
  a_addr_mirror: assert property (p_addr_mirror)
    else $error("fault address readback wrong");
  property p_host_active;
    !$past(i_guest_mode) |-> o_host_entries_active;
  endproperty
  a_host_active: assert property (p_host_active)
    else $error("host entries off in host mode");
  property p_guest_off;
    !$past(i_guest_mode) |-> !o_guest_entries_active;
  endproperty
  a_guest_off: assert property (p_guest_off)
    else $error("guest entries on in host mode");
endmodule
bind guest_fault_mpu_regs guest_fault_mpu_regs_asserts #(
  .FIXED_CORE_NUM(FIXED_CORE_NUM)) chk_u (.i_clk(i_clk), .i_rst(i_rst),
  .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
  .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
  .i_guest_mode(i_guest_mode), .i_fault_commit(i_fault_commit),
  .i_misaligned_fault(i_misaligned_fault),
  .i_data_prot_fault(i_data_prot_fault),
  .i_fault_address(i_fault_address), .o_pready(o_pready),
  .o_prdata(o_prdata), .o_host_entries_active(o_host_entries_active),
  .o_guest_entries_active(o_guest_entries_active),
  .o_core_number(o_core_number), .o_ext_core_number(o_ext_core_number));

// *** tb/testbench.sv ***
// self-checking bench for the guest fault and protection register bank
`timescale 1ns/10ps
module testbench;
  localparam logic [4:0] FIXED = 5'h0a; // arbitrary product value
  logic i_clk = 1'b0, i_rst = 1'b1, i_psel = 1'b0, i_penable = 1'b0;
  logic i_pwrite = 1'b0, i_guest_mode = 1'b0, i_user_mode_flag = 1'b0;
  logic i_fault_commit = 1'b0, i_misaligned_fault = 1'b0;
  logic i_data_prot_fault = 1'b0, i_sign_ext = 1'b1, i_fault_write = 1'b1;
  logic [7:0] i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0000_0000, i_fault_address = 32'h0000_0000;
  logic [3:0] i_pstrb = 4'hf, i_opcode_size = 4'h6;
  logic [4:0] i_operand_index = 5'h13, i_faulting_op_kind = 5'h11;
  logic [2:0] i_access_width_type = 3'h5;
  logic o_pready, o_pslverr, o_host_entries_active, o_guest_entries_active;
  logic [31:0] o_prdata;
  logic [4:0] o_core_number, o_ext_core_number;
  int n_mismatch = 0, checked = 0;
  always #2.5 i_clk = ~i_clk;
  guest_fault_mpu_regs #(.FIXED_CORE_NUM(FIXED)) dut_u (.i_clk(i_clk),
    .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .i_pstrb(i_pstrb), .i_guest_mode(i_guest_mode),
    .i_user_mode_flag(i_user_mode_flag), .i_fault_commit(i_fault_commit),
    .i_misaligned_fault(i_misaligned_fault),
    .i_data_prot_fault(i_data_prot_fault),
    .i_fault_address(i_fault_address), .i_opcode_size(i_opcode_size),
    .i_operand_index(i_operand_index),
    .i_access_width_type(i_access_width_type), .i_sign_ext(i_sign_ext),
    .i_faulting_op_kind(i_faulting_op_kind), .i_fault_write(i_fault_write),
    .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
    .o_host_entries_active(o_host_entries_active),
    .o_guest_entries_active(o_guest_entries_active),
    .o_core_number(o_core_number), .o_ext_core_number(o_ext_core_number));
  // ==========================================================
  // shared tasks
  task automatic conclude();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
    int i;
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge i_clk);
      if (o_pready === 1'b1) break;
    end
    if (i == 20) begin
      n_mismatch++;
      conclude();
    end
    r = o_prdata;
    e = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk({r[31:1], r[0] | e}, exp);
  endtask
  task automatic mode(input logic g, input logic u);
    @(posedge i_clk);
    i_guest_mode <= g;
    i_user_mode_flag <= u;
    repeat (2) @(posedge i_clk);
  endtask
  task automatic fault(input logic g, input logic m, input logic [31:0] a);
    @(posedge i_clk);
    i_guest_mode <= g;
    i_fault_commit <= 1'b1;
    i_misaligned_fault <= m;
    i_data_prot_fault <= !m;
    i_fault_address <= a;
    @(posedge i_clk);
    i_fault_commit <= 1'b0;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_fault();
    fault(1'b1, 1'b1, 32'h8000_1236);
    rd(8'h00, 32'h8000_1236);
    rd(8'h04, 32'h6013_0b23);
    fault(1'b0, 1'b0, 32'h0000_0040);
    rd(8'h00, 32'h8000_1236);
    fault(1'b1, 1'b0, 32'h0000_0044);
    rd(8'h00, 32'h0000_0044);
    wr(8'h04, 32'hffff_fffe);
    rd(8'h04, 32'hf01f_0f3e);
  endtask
  task automatic t_prot();
    mode(1'b0, 1'b0);
    wr(8'h08, 32'hffff_ffff);
    rd(8'h08, 32'h0000_0007);
    mode(1'b1, 1'b0);
    wr(8'h08, 32'h0000_0000);
    rd(8'h08, 32'h0000_0004);
    wr(8'h10, 32'h0000_0001);
    wr(8'h14, 32'h0000_0003);
    rd(8'h08, 32'h0000_0004);
    wr(8'h08, 32'h0000_0003);
    rd(8'h08, 32'h0000_0007);
    rd(8'h1c, 32'h0000_0003);
    wr(8'h08, 32'h0000_0001);
    rd(8'h1c, 32'h0000_0002);
    mode(1'b1, 1'b1);
    chk({30'h0, o_host_entries_active, o_guest_entries_active}, 3);
    wr(8'h08, 32'h0000_0000);
    rd(8'h1c, 32'h0000_0002);
    mode(1'b0, 1'b0);
    wr(8'h08, 32'h0000_0001);
    mode(1'b1, 1'b1);
    rd(8'h1c, 32'h0000_0001);
    wr(8'h10, 32'h0000_0000);
  endtask
  task automatic t_core();
    mode(1'b0, 1'b0);
    wr(8'h0c, 32'hffff_ffff);
    rd(8'h0c, 32'h0000_001f);
    rd(8'h18, {27'h0, FIXED});
    mode(1'b1, 1'b0);
    rd(8'h18, 32'h0000_001f);
    chk({27'h0, o_core_number}, 32'h0000_001f);
    chk({27'h0, o_ext_core_number}, {27'h0, FIXED});
    wr(8'h18, 32'h0000_0003);
    rd(8'h0c, 32'h0000_001f);
  endtask
  initial begin
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(8'h08, 32'h0000_0000);
    rd(8'h1c, 32'h0000_0002);
    t_fault();
    t_prot();
    t_core();
    rd(8'h20, 32'h0000_0001);
    conclude();
  end
endmodule
